/* File: rtl/fpc_counter.v */
// One fixed-function counter with qualification and overflow detection
`default_nettype none
`include "fpc_defines.vh"

module fpc_counter (
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_sys_rst,
  // Qualification
  input  wire [3:0]  i_ctl,
  input  wire        i_gen,
  input  wire        i_freeze,
  input  wire        i_ring0,
  input  wire [47:0] i_inc,
  // Software load
  input  wire        i_wr,
  input  wire [47:0] i_wdata,
  // State
  output wire [47:0] o_count,
  output wire        o_ovf
);

  reg  [47:0] cnt_r;
  reg  [47:0] cnt_nxt;
  reg         ovf_r;
  wire        priv_ok;
  wire        run;
  wire [48:0] sum;

  assign priv_ok = i_ring0 ? i_ctl[`FPC_CF_RING0] : i_ctl[`FPC_CF_RINGN];
  assign run     = i_gen & priv_ok & ~i_freeze;
  assign sum     = {1'b0, cnt_r} + {1'b0, i_inc};
  assign o_count = cnt_r;
  assign o_ovf   = ovf_r;

  // Software write wins over counting
  always @* begin
    cnt_nxt = cnt_r;
    if (i_wr) begin
      cnt_nxt = i_wdata;
    end else if (run) begin
      cnt_nxt = sum[47:0];
    end
  end

  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_r <= `FPC_RST_CTR;
      ovf_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      ovf_r <= ~i_wr & run & sum[48];
    end
  end

endmodule // fpc_counter
`default_nettype wire

/* File: rtl/fpc_defines.vh */
// Constants for the fixed performance counter unit
`ifndef FPC_DEFINES_VH
`define FPC_DEFINES_VH

// Register addresses (model-specific register space)
`define FPC_ADDR_CTR0      12'h309
`define FPC_ADDR_CTR1      12'h30a
`define FPC_ADDR_CTR2      12'h30b
`define FPC_ADDR_CTR3      12'h30c
`define FPC_ADDR_FIXCTL    12'h38d
`define FPC_ADDR_GSTATUS   12'h38e
`define FPC_ADDR_GENABLE   12'h38f
`define FPC_ADDR_GOVFCLR   12'h390
`define FPC_ADDR_DBGCTL    12'h1d9

// Counter geometry and capability fields
`define FPC_NUM_FIXED      5'h04
`define FPC_CTR_WIDTH      8'h30
`define FPC_CAP_NUM_LSB    0
`define FPC_CAP_WID_LSB    5

// Control field layout within each 4-bit block
`define FPC_CF_RING0       0
`define FPC_CF_RINGN       1
`define FPC_CF_INT         3

// Global register bit positions
`define FPC_GBIT_GP0       0
`define FPC_GBIT_GP1       1
`define FPC_GBIT_FIX0      32

// Debug control bit positions
`define FPC_DBG_FRZ_BR     11
`define FPC_DBG_FRZ_CTR    12

// Slot increment per unhalted cycle
`define FPC_SLOT_WIDTH     48'h4

// Reset values
`define FPC_RST_ZERO64     64'h0
`define FPC_RST_CTR        48'h0

`endif

/* File: rtl/fpc_unit.v */
// Fixed performance counter unit with global control and status
//
// Overview of operation
// - Fixed counters each hard-wired to one event, no event select needed.
// - All fixed counters configured through one control register at 38DH.
// - One global enable write enables any mix of counters.
// - One status read reports all counter overflows.
// - One overflow-clear write clears selected overflow indications.
// - Debug control holds freeze bits 11 and 12, legacy behaviour only.
// - Capability bits 0..4 give number of fixed counters.
// - Capability bits 5..12 give fixed counter width.
// - One 4-bit control field per counter, governing only that counter.
// - Control bit 0 enables counting at ring zero.
// - Control bit 1 enables counting at rings above zero.
// - Both enables clear stops; both set counts at any level.
// - Control bit 3 lets that counter's overflow raise an interrupt.
// - Counting needs global enable AND privilege enables.
// - Counter 0 counts retired instructions, including in interrupt handlers.
// - Counter 1 counts unhalted core cycles.
// - Counter 2 counts reference cycles when unhalted and not stop-clocked.
// - Halt or monitor-wait execution counts as halted.
// - Counter 3 adds pipeline slot width each unhalted cycle.
// - Status bits 0, 1, 32..34 (and 35) flag counter overflow.
`default_nettype none
`include "fpc_defines.vh"

module fpc_unit (
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_sys_rst,
  // Model register access
  input  wire        i_reg_wr,
  input  wire        i_reg_rd,
  input  wire [11:0] i_reg_addr,
  input  wire [63:0] i_reg_wdata,
  output reg  [63:0] o_reg_rdata,
  output reg         o_reg_ack,
  output reg         o_reg_fault,
  // Core event sources (same clock)
  input  wire        i_ring0,
  input  wire        i_instr_retired,
  input  wire        i_halt_exec,
  input  wire        i_monitor_wait_instruction_exec,
  input  wire        i_wake,
  input  wire        i_stop_clock,
  input  wire        i_ref_tick,
  input  wire        i_gp_ovf0,
  input  wire        i_gp_ovf1,
  // Capability and status outputs
  output reg  [31:0] o_cap_fixed,
  output reg         o_perf_overflow_interrupt,
  output reg  [63:0] o_global_count_enable,
  output reg         o_freeze_branch_records
);

  reg  [63:0] fixctl_r;
  reg  [63:0] gen_r;
  reg  [63:0] gstat_r;
  reg  [63:0] gstat_nxt;
  reg  [63:0] dbg_r;
  reg         halted_r;
  reg  [63:0] rdata_nxt;
  reg         hit_nxt;
  wire [47:0] cnt0;
  wire [47:0] cnt1;
  wire [47:0] cnt2;
  wire [47:0] cnt3;
  wire [3:0]  ovf;
  wire        unhalted;
  wire        frz;
  wire        irq_any;
  wire [3:0]  ctr_wr;
  wire        fix_wr;
  wire        gen_wr;
  wire        clr_wr;
  wire        dbg_wr;
  wire [47:0] inc0;
  wire [47:0] inc1;
  wire [47:0] inc2;
  wire [47:0] inc3;

  // Address match on write; strobe and address are arguments so that
  // every caller re-evaluates when either of them changes
  function wr_hit;
    input        wr;
    input [11:0] addr;
    input [11:0] a;
    begin
      wr_hit = wr & (addr == a);
    end
  endfunction

  // Zero-extend a counter to a 64-bit read word
  function [63:0] ext;
    input [47:0] c;
    begin
      ext = {16'h0000, c};
    end
  endfunction

  // Interrupt enable of counter n within the control word
  function int_en;
    input [63:0] ctl;
    input [1:0]  n;
    begin
      int_en = ctl[4 * n + `FPC_CF_INT];
    end
  endfunction

  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      halted_r <= 1'b0;
    end else if (i_halt_exec | i_monitor_wait_instruction_exec) begin
      halted_r <= 1'b1;
    end else if (i_wake) begin
      halted_r <= 1'b0;
    end
  end

  assign unhalted = ~halted_r;
  // freeze counters while an interrupt is pending
  assign frz      = dbg_r[`FPC_DBG_FRZ_CTR] & o_perf_overflow_interrupt;

  // Write strobes, one per register except the read-only global status
  assign ctr_wr[0] = wr_hit(i_reg_wr, i_reg_addr, `FPC_ADDR_CTR0);
  assign ctr_wr[1] = wr_hit(i_reg_wr, i_reg_addr, `FPC_ADDR_CTR1);
  assign ctr_wr[2] = wr_hit(i_reg_wr, i_reg_addr, `FPC_ADDR_CTR2);
  assign ctr_wr[3] = wr_hit(i_reg_wr, i_reg_addr, `FPC_ADDR_CTR3);
  assign fix_wr    = wr_hit(i_reg_wr, i_reg_addr, `FPC_ADDR_FIXCTL);
  assign gen_wr    = wr_hit(i_reg_wr, i_reg_addr, `FPC_ADDR_GENABLE);
  assign clr_wr    = wr_hit(i_reg_wr, i_reg_addr, `FPC_ADDR_GOVFCLR);
  assign dbg_wr    = wr_hit(i_reg_wr, i_reg_addr, `FPC_ADDR_DBGCTL);

  assign inc0 = {47'h0, i_instr_retired};
  assign inc1 = {47'h0, unhalted};
  // reference tick outside halt and stop-clock
  assign inc2 = {47'h0, unhalted & ~i_stop_clock & i_ref_tick};
  assign inc3 = unhalted ? `FPC_SLOT_WIDTH : 48'h0;

  fpc_counter u_ctr0 (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_ctl     (fixctl_r[3:0]),
    .i_gen     (gen_r[`FPC_GBIT_FIX0]),
    .i_freeze  (frz),
    .i_ring0   (i_ring0),
    .i_inc     (inc0),
    .i_wr      (ctr_wr[0]),
    .i_wdata   (i_reg_wdata[47:0]),
    .o_count   (cnt0),
    .o_ovf     (ovf[0])
  );

  fpc_counter u_ctr1 (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_ctl     (fixctl_r[7:4]),
    .i_gen     (gen_r[`FPC_GBIT_FIX0+1]),
    .i_freeze  (frz),
    .i_ring0   (i_ring0),
    .i_inc     (inc1),
    .i_wr      (ctr_wr[1]),
    .i_wdata   (i_reg_wdata[47:0]),
    .o_count   (cnt1),
    .o_ovf     (ovf[1])
  );

  fpc_counter u_ctr2 (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_ctl     (fixctl_r[11:8]),
    .i_gen     (gen_r[`FPC_GBIT_FIX0+2]),
    .i_freeze  (frz),
    .i_ring0   (i_ring0),
    .i_inc     (inc2),
    .i_wr      (ctr_wr[2]),
    .i_wdata   (i_reg_wdata[47:0]),
    .o_count   (cnt2),
    .o_ovf     (ovf[2])
  );

  fpc_counter u_ctr3 (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_ctl     (fixctl_r[15:12]),
    .i_gen     (gen_r[`FPC_GBIT_FIX0+3]),
    .i_freeze  (frz),
    .i_ring0   (i_ring0),
    .i_inc     (inc3),
    .i_wr      (ctr_wr[3]),
    .i_wdata   (i_reg_wdata[47:0]),
    .o_count   (cnt3),
    .o_ovf     (ovf[3])
  );

  // sticky status, set wins over clear
  always @* begin
    gstat_nxt = gstat_r;
    if (clr_wr) begin
      gstat_nxt = gstat_r & ~i_reg_wdata;
    end
    gstat_nxt[`FPC_GBIT_GP0] = gstat_nxt[`FPC_GBIT_GP0] | i_gp_ovf0;
    gstat_nxt[`FPC_GBIT_GP1] = gstat_nxt[`FPC_GBIT_GP1] | i_gp_ovf1;
    gstat_nxt[35:32] = gstat_nxt[35:32] | ovf;
    gstat_nxt[31:2] = 30'h0;
    gstat_nxt[63:36] = 28'h0;
  end

  // interrupt from enabled fixed counter overflow
  assign irq_any = (gstat_nxt[32] & int_en(fixctl_r, 2'h0))
                 | (gstat_nxt[33] & int_en(fixctl_r, 2'h1))
                 | (gstat_nxt[34] & int_en(fixctl_r, 2'h2))
                 | (gstat_nxt[35] & int_en(fixctl_r, 2'h3));

  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      gstat_r <= `FPC_RST_ZERO64;
    end else begin
      gstat_r <= gstat_nxt;
    end
  end

  // fixed control, one nibble per counter
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      fixctl_r <= `FPC_RST_ZERO64;
    end else if (fix_wr) begin
      fixctl_r <= {48'h0, i_reg_wdata[15:0]}; // Nibbles above counter 3 read zero
    end
  end

  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      gen_r <= `FPC_RST_ZERO64;
    end else if (gen_wr) begin
      gen_r <= {28'h0, i_reg_wdata[35:32], 30'h0, i_reg_wdata[1:0]};
    end
  end

  // freeze bits only; other debug bits live elsewhere
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dbg_r <= `FPC_RST_ZERO64;
    end else if (dbg_wr) begin
      dbg_r <= {51'h0, i_reg_wdata[`FPC_DBG_FRZ_CTR:`FPC_DBG_FRZ_BR], 11'h0};
    end
  end

  always @* begin
    rdata_nxt = 64'h0;
    hit_nxt   = 1'b1;
    case (i_reg_addr)
      `FPC_ADDR_CTR0:    rdata_nxt = ext(cnt0);
      `FPC_ADDR_CTR1:    rdata_nxt = ext(cnt1);
      `FPC_ADDR_CTR2:    rdata_nxt = ext(cnt2);
      `FPC_ADDR_CTR3:    rdata_nxt = ext(cnt3);
      `FPC_ADDR_FIXCTL:  rdata_nxt = fixctl_r;
      `FPC_ADDR_GENABLE: rdata_nxt = gen_r;
      `FPC_ADDR_GSTATUS: rdata_nxt = gstat_r;
      `FPC_ADDR_DBGCTL:  rdata_nxt = dbg_r;
      `FPC_ADDR_GOVFCLR: rdata_nxt = 64'h0; // Write-only reads zero
      default:           hit_nxt   = 1'b0;
    endcase
  end

  // Bus answer, one cycle after the strobe
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_reg_rdata <= 64'h0;
      o_reg_ack   <= 1'b0;
      o_reg_fault <= 1'b0;
    end else begin
      o_reg_ack   <= i_reg_rd | i_reg_wr;
      o_reg_fault <= (i_reg_rd | i_reg_wr) & ~hit_nxt;
      o_reg_rdata <= i_reg_rd ? rdata_nxt : 64'h0;
    end
  end

  // Status outputs; interrupt taken from the next status so that it
  // rises on the same edge as the sticky bit
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_cap_fixed               <= 32'h0;
      o_perf_overflow_interrupt <= 1'b0;
      o_global_count_enable     <= 64'h0;
      o_freeze_branch_records   <= 1'b0;
    end else begin
      o_cap_fixed <= {19'h0, `FPC_CTR_WIDTH, `FPC_NUM_FIXED};
      // level while an enabled overflow is pending
      o_perf_overflow_interrupt <= irq_any;
      o_global_count_enable     <= gen_r;
      o_freeze_branch_records <= dbg_r[`FPC_DBG_FRZ_BR] & irq_any;
    end
  end

endmodule // fpc_unit
`default_nettype wire

/* File: test/fpc_unit_sva.sv */
// Port checker for the fixed performance counter unit
`default_nettype none
module fpc_unit_sva (
  // Clock, reset, register bus
  input wire logic        i_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_reg_wr,
  input wire logic        i_reg_rd,
  input wire logic [11:0] i_reg_addr,
  input wire logic [63:0] i_reg_wdata,
  input wire logic [63:0] o_reg_rdata,
  input wire logic        o_reg_ack,
  input wire logic        o_reg_fault,
  // Status outputs
  input wire logic [31:0] o_cap_fixed,
  input wire logic        o_perf_overflow_interrupt,
  input wire logic [63:0] o_global_count_enable,
  input wire logic        o_freeze_branch_records
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  // Request and mapped-address decode
  wire req = i_reg_wr | i_reg_rd;
  wire hit = (i_reg_addr >= 12'h309 && i_reg_addr <= 12'h30c) || i_reg_addr == 12'h1d9 ||
             (i_reg_addr >= 12'h38d && i_reg_addr <= 12'h390);
  sequence s_req;
    req;
  endsequence
  sequence s_enable_wr;
    i_reg_wr && i_reg_addr == 12'h38f;
  endsequence
  a_ack_after_req: assert property (s_req |=> o_reg_ack)
    else $error("no ack after request");
  a_ack_needs_req: assert property (o_reg_ack |-> $past(req))
    else $error("ack without request");
  a_fault_unmapped: assert property (s_req ##0 !hit |=> o_reg_fault && o_reg_rdata == 64'h0)
    else $error("unmapped access not refused");
  a_no_fault_mapped: assert property (s_req ##0 hit |=> !o_reg_fault)
    else $error("fault on mapped address");
  a_write_data_zero: assert property (i_reg_wr |=> o_reg_rdata == 64'h0)
    else $error("read data on write ack");
  a_cap_word: assert property (!$past(i_sys_rst) |-> o_cap_fixed == 32'h0000_0604)
    else $error("capability word wrong");
  a_enable_copy: assert property (s_enable_wr |=> ##1
    o_global_count_enable == ($past(i_reg_wdata, 2) & 64'h0000_000f_0000_0003))
    else $error("global enable copy wrong");
  a_freeze_needs_int: assert property (o_freeze_branch_records |-> o_perf_overflow_interrupt)
    else $error("branch freeze without interrupt");
endmodule // fpc_unit_sva
bind fpc_unit fpc_unit_sva u_sva (.i_clk, .i_sys_rst, .i_reg_wr, .i_reg_rd, .i_reg_addr,
  .i_reg_wdata, .o_reg_rdata, .o_reg_ack, .o_reg_fault, .o_cap_fixed,
  .o_perf_overflow_interrupt, .o_global_count_enable, .o_freeze_branch_records);
`default_nettype wire

/* File: test/test_fpc_unit.sv */
// Self-checking bench for the fixed performance counter unit
`default_nettype none
module test_fpc_unit;
  timeunit 1ns;
  timeprecision 1ps;
  // Inputs, changed on the falling edge
  logic        i_clk = 1'h0, i_sys_rst = 1'h1, i_reg_wr = 1'h0, i_reg_rd = 1'h0;
  logic [11:0] i_reg_addr = 12'h0;
  logic [63:0] i_reg_wdata = 64'h0;
  logic        i_ring0 = 1'h1, i_instr_retired = 1'h0, i_halt_exec = 1'h0, i_wake = 1'h0;
  logic        i_monitor_wait_instruction_exec = 1'h0, i_stop_clock = 1'h0, i_ref_tick = 1'h0;
  logic        i_gp_ovf0 = 1'h0, i_gp_ovf1 = 1'h0;
  wire  [63:0] o_reg_rdata, o_global_count_enable;
  wire         o_reg_ack, o_reg_fault, o_perf_overflow_interrupt, o_freeze_branch_records;
  wire  [31:0] o_cap_fixed;
  logic [63:0] rdat, v1;
  int          failures = 0, samples_checked = 0, cyc = 0;
  fpc_unit dut (.i_clk, .i_sys_rst, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata,
    .o_reg_rdata, .o_reg_ack, .o_reg_fault, .i_ring0, .i_instr_retired, .i_halt_exec,
    .i_monitor_wait_instruction_exec, .i_wake, .i_stop_clock, .i_ref_tick, .i_gp_ovf0, .i_gp_ovf1, .o_cap_fixed,
    .o_perf_overflow_interrupt, .o_global_count_enable, .o_freeze_branch_records);
  // 40 MHz clock
  always #12.5 i_clk = ~i_clk;
  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      failures++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One register access; answer sampled while ack stands
  task automatic acc(input logic w, input logic [11:0] a, input logic [63:0] d);
    @(negedge i_clk);
    i_reg_wr = w;
    i_reg_rd = !w;
    i_reg_addr = a;
    i_reg_wdata = d;
    @(negedge i_clk);
    i_reg_wr = 1'h0;
    i_reg_rd = 1'h0;
    rdat = o_reg_rdata;
    chk(o_reg_ack, 64'h1);
    chk(o_reg_fault, a == 12'h123);
  endtask
  task automatic pulse(ref logic s);
    @(negedge i_clk);
    s = 1'h1;
    @(negedge i_clk);
    s = 1'h0;
  endtask
  // Two reads two cycles apart; growth must be twice the per-cycle rate
  task automatic rate(input logic [11:0] a, input logic [63:0] d);
    acc(1'h0, a, 64'h0);
    v1 = rdat;
    acc(1'h0, a, 64'h0);
    chk(rdat - v1, d);
  endtask
  // Three retirements under a control value and ring
  task automatic cnt(input logic [63:0] ctl, input logic ring, input logic [63:0] exp);
    acc(1'h1, 12'h38d, ctl);
    acc(1'h1, 12'h309, 64'h0);
    i_ring0 = ring;
    repeat (3) pulse(i_instr_retired);
    repeat (2) @(negedge i_clk);
    acc(1'h0, 12'h309, 64'h0);
    chk(rdat, exp);
  endtask
  task automatic t_reset();
    for (int a = 12'h309; a <= 12'h390; a += (a == 12'h30c) ? 12'h81 : 1) begin
      acc(1'h0, a[11:0], 64'h0);
      chk(rdat, 64'h0);
    end
    chk(o_cap_fixed, 64'h604);
    acc(1'h0, 12'h123, 64'h0);
    chk(rdat, 64'h0);
  endtask
  task automatic t_qual();
    acc(1'h1, 12'h38f, 64'h1_0000_0000);
    cnt(64'h1, 1'h1, 64'h3);
    cnt(64'h1, 1'h0, 64'h0);
    cnt(64'h2, 1'h0, 64'h3);
    cnt(64'h2, 1'h1, 64'h0);
    cnt(64'h0, 1'h1, 64'h0);
    cnt(64'h3, 1'h0, 64'h3);
    cnt(64'h30, 1'h1, 64'h0);
    acc(1'h1, 12'h38f, 64'h0);
    cnt(64'h3, 1'h1, 64'h0);
  endtask
  task automatic t_cycles();
    acc(1'h1, 12'h38f, 64'hf_0000_0000);
    acc(1'h1, 12'h38d, 64'h3333);
    chk(o_global_count_enable, 64'hf_0000_0000);
    i_ref_tick = 1'h1;
    rate(12'h30a, 64'h2);
    rate(12'h30b, 64'h2);
    rate(12'h30c, 64'h8);
    i_stop_clock = 1'h1;
    rate(12'h30b, 64'h0);
    i_stop_clock = 1'h0;
    pulse(i_halt_exec);
    rate(12'h30a, 64'h0);
    rate(12'h30c, 64'h0);
    pulse(i_wake);
    pulse(i_monitor_wait_instruction_exec);
    rate(12'h30b, 64'h0);
    pulse(i_wake);
    rate(12'h30a, 64'h2);
  endtask
  task automatic t_ovf();
    acc(1'h1, 12'h38f, 64'h3_0000_0003);
    acc(1'h1, 12'h38d, 64'h39);
    chk(o_global_count_enable, 64'h3_0000_0003);
    acc(1'h1, 12'h309, 64'hffff_ffff_ffff);
    pulse(i_instr_retired);
    pulse(i_gp_ovf0);
    pulse(i_gp_ovf1);
    acc(1'h1, 12'h38e, 64'h0);
    acc(1'h0, 12'h38e, 64'h0);
    chk(rdat, 64'h1_0000_0003);
    chk(o_perf_overflow_interrupt, 64'h1);
    acc(1'h1, 12'h1d9, 64'h1800);
    rate(12'h30a, 64'h0);
    chk(o_freeze_branch_records, 64'h1);
    acc(1'h1, 12'h390, 64'h1_0000_0001);
    acc(1'h0, 12'h38e, 64'h0);
    chk(rdat, 64'h2);
    acc(1'h1, 12'h390, 64'h2);
    rate(12'h30a, 64'h2);
    chk(o_perf_overflow_interrupt, 64'h0);
    acc(1'h0, 12'h1d9, 64'h0);
    chk(rdat, 64'h1800);
  endtask
  // Main sequence
  initial begin
    repeat (8) @(negedge i_clk);
    i_sys_rst = 1'h0;
    t_reset();
    t_qual();
    t_cycles();
    t_ovf();
    results();
  end
endmodule // test_fpc_unit
`default_nettype wire
